// file: rfm_pkg.sv
// Shared constants and types of the rail fault response monitor
package rfm_pkg;
    // ==============================================================
    // Time base
    localparam int CLK_HZ = 100_000_000;
    localparam int MS_US = 1000;
    localparam int GLITCH_V_US = 400;
    localparam int SAMPLE_MS = 100;
    localparam int RESTART_STEP_MS = 5;
    localparam int MS_CYC = CLK_HZ / 1_000_000 * MS_US;
    localparam int GLITCH_V_CYC = CLK_HZ / 1_000_000 * GLITCH_V_US;
    localparam int SAMPLE_CYC = MS_CYC * SAMPLE_MS;
    // ==============================================================
    // Data widths and averaging
    localparam int ADC_W = 12;
    localparam int VAL_W = 16;
    localparam int TMR_W = 12;
    localparam int AVG_DEPTH = 16;
    localparam int AVG_SHIFT = 4;
    localparam int MAX_RETRY = 14;
    localparam int VREF_NUM = 5;
    localparam int VREF_SHIFT = 13;
    localparam int NOM_SHIFT = 3;
    // ==============================================================
    // Register map: rail r at byte r*64, word index below
    localparam int RAIL_SHIFT = 6;
    localparam int W_OVF = 0;
    localparam int W_OVW = 1;
    localparam int W_UVW = 2;
    localparam int W_UVF = 3;
    localparam int W_PGON = 4;
    localparam int W_PGOFF = 5;
    localparam int W_NOM = 6;
    localparam int W_CTRL = 7;
    localparam int W_TLIM = 8;
    localparam int W_WAIT = 9;
    localparam int W_RSTRT = 10;
    localparam int W_TCAL = 11;
    localparam int W_STAT = 12;
    localparam int W_READ = 13;
    localparam int W_NUM = 14;
    localparam logic [31:0] RST_OV = 32'h0000FFFF;
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    // ==============================================================
    // Field positions
    localparam int F_ON = 0;
    localparam int F_RESP = 1;
    localparam int F_RST = 3;
    localparam int F_RETRY = 5;
    localparam int F_FEN = 9;
    localparam int F_TYPE = 10;
    localparam int F_FILT = 12;
    localparam int F_HI = 16;
    localparam int F_SLV = 8;
    // Status bits
    localparam int S_OVF = 0;
    localparam int S_OVW = 1;
    localparam int S_UVW = 2;
    localparam int S_UVF = 3;
    localparam int S_TON = 4;
    localparam int S_TOFF = 5;
    localparam int S_W = 6;
    // ==============================================================
    // Mode codes
    localparam logic [1:0] RESP_CONT = 2'h0;
    localparam logic [1:0] RESP_IMM = 2'h1;
    localparam logic [1:0] RESP_DELAY = 2'h2;
    localparam logic [1:0] RESP_RESEQ = 2'h3;
    localparam logic [1:0] RST_NONE = 2'h0;
    localparam logic [1:0] RST_COUNT = 2'h1;
    localparam logic [1:0] RST_CONT = 2'h2;
    localparam logic [1:0] TYPE_VOLT = 2'h0;
    localparam logic [1:0] TYPE_TEMP = 2'h2;

    typedef enum logic [2:0] {
        RS_IDLE, RS_ONWAIT, RS_RAMP, RS_ON, RS_OFFWAIT, RS_FALL, RS_RETRY, RS_LOCK
    } rfm_rail_t;
endpackage

// file: rfm_monitor.sv
// Rail health monitor with fault response, APB register slave
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module rfm_monitor
    import rfm_pkg::*;
#(
    parameter int NUM_RAILS = 4,
    parameter int MS_CYCLES = MS_CYC,
    parameter int GLITCH_CYCLES = GLITCH_V_CYC,
    parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // ADC result stream
    input wire logic adcValid,
    input wire logic [3:0] adcChan,
    input wire logic [ADC_W-1:0] adcData,
    // Pins
    input wire logic bus_control_pin,
    output logic [NUM_RAILS-1:0] railEnable,
    output logic alert_out_n
);
    localparam int SW = ADC_W + AVG_SHIFT;

    // ==============================================================
    // Time base
    logic [23:0] msCnt;
    logic [23:0] glCnt;
    logic [23:0] smpCnt;
    logic [3:0] smpPtr;
    wire msTick = (msCnt == 24'(MS_CYCLES - 1));
    wire glTick = (glCnt == 24'(GLITCH_CYCLES - 1));
    wire smpTick = (smpCnt == 24'(SAMPLE_CYCLES - 1));

    always_ff @(posedge ref_clk) begin
        if (srst || msTick) msCnt <= 24'h000000;
        else msCnt <= msCnt + 24'h000001;
    end
    always_ff @(posedge ref_clk) begin
        if (srst || glTick) glCnt <= 24'h000000;
        else glCnt <= glCnt + 24'h000001;
    end
    always_ff @(posedge ref_clk) begin
        if (srst || smpTick) smpCnt <= 24'h000000;
        else smpCnt <= smpCnt + 24'h000001;
    end
    always_ff @(posedge ref_clk) begin
        if (srst) smpPtr <= 4'h0;
        else if (smpTick) smpPtr <= (smpPtr == 4'(NUM_RAILS - 1)) ? 4'h0 : smpPtr + 4'h1;
    end

    // ==============================================================
    // Control pin synchroniser
    logic pinS1;
    logic pinS2;
    logic pinS3;
    logic ctlPin;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pinS1 <= 1'b0;
            pinS2 <= 1'b0;
            pinS3 <= 1'b0;
            ctlPin <= 1'b0;
        end else begin
            pinS1 <= bus_control_pin;
            pinS2 <= pinS1;
            pinS3 <= pinS2;
            if (pinS2 == pinS3) ctlPin <= pinS3;
        end
    end

    // ==============================================================
    // APB decode and configuration storage
    logic [31:0] cfg [NUM_RAILS][W_STAT];
    logic [5:0] status [NUM_RAILS];
    logic [3:0] retries [NUM_RAILS];
    rfm_rail_t st [NUM_RAILS];
    logic [VAL_W-1:0] mv [NUM_RAILS];
    logic [VAL_W-1:0] tempC [NUM_RAILS];
    logic [NUM_RAILS-1:0] shutOut;
    logic [NUM_RAILS-1:0] reseqOut;
    logic [NUM_RAILS-1:0] shutIn;
    logic [NUM_RAILS-1:0] reseqIn;
    logic [NUM_RAILS-1:0] statAny;
    logic [31:0] rdWord;

    wire [3:0] railIdx = paddr[RAIL_SHIFT +: 4];
    wire [3:0] wordIdx = paddr[5:2];
    wire hit = (paddr[11:10] == 2'h0) && (railIdx < 4'(NUM_RAILS)) && (wordIdx < 4'(W_NUM));
    wire setup = psel && !penable;
    wire wr = psel && penable && pready && pwrite && hit;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup && !hit;
            if (setup) prdata <= rdWord;
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int r = 0; r < NUM_RAILS; r++) begin
            for (int w = 0; w < W_STAT; w++) begin
                if (srst) cfg[r][w] <= (w == W_OVF || w == W_OVW) ? RST_OV : RST_ZERO;
                else if (wr && railIdx == 4'(r) && wordIdx == 4'(w)) cfg[r][w] <= pwdata;
            end
        end
    end

    always_comb begin
        rdWord = 32'h00000000;
        for (int r = 0; r < NUM_RAILS; r++) begin
            if (hit && railIdx == 4'(r)) begin
                if (wordIdx < 4'(W_STAT)) rdWord = cfg[r][wordIdx];
                else if (wordIdx == 4'(W_STAT)) rdWord = {17'h00000, st[r], retries[r], 2'h0, status[r]};
                else rdWord = {tempC[r], mv[r]};
            end
        end
    end

    // Fault-shutdown slave fan-out
    always_comb begin
        shutIn = '0;
        reseqIn = '0;
        for (int f = 0; f < NUM_RAILS; f++) begin
            for (int s = 0; s < NUM_RAILS; s++) begin
                if (cfg[f][W_RSTRT][F_SLV + s] && f != s) begin
                    shutIn[s] = shutIn[s] | shutOut[f];
                    reseqIn[s] = reseqIn[s] | reseqOut[f];
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) alert_out_n <= 1'b1;
        else alert_out_n <= !(|statAny);
    end

    // ==============================================================
    // Per-rail monitor and sequencer
    for (genvar r = 0; r < NUM_RAILS; r++) begin : gRail
        wire [31:0] ctrl = cfg[r][W_CTRL];
        wire [1:0] resp = ctrl[F_RESP +: 2];
        wire [1:0] rst = ctrl[F_RST +: 2];
        wire [1:0] kind = ctrl[F_TYPE +: 2];
        wire [3:0] retryN = ctrl[F_RETRY +: 4];
        wire [7:0] filt = ctrl[F_FILT +: 8];
        wire isTemp = (kind == TYPE_TEMP);
        wire enReq = ctlPin && ctrl[F_ON];
        wire [TMR_W-1:0] tonMax = cfg[r][W_TLIM][TMR_W-1:0];
        wire [TMR_W-1:0] toffMax = cfg[r][W_TLIM][F_HI +: TMR_W];
        wire [TMR_W-1:0] onWait = cfg[r][W_WAIT][TMR_W-1:0];
        wire [TMR_W-1:0] offWait = cfg[r][W_WAIT][F_HI +: TMR_W];
        wire [TMR_W-1:0] restartT = TMR_W'(cfg[r][W_RSTRT][7:0]) * TMR_W'(RESTART_STEP_MS);

        // Temperature averaging
        logic [ADC_W-1:0] hist [AVG_DEPTH];
        logic [3:0] hPtr;
        logic [SW-1:0] sum;
        logic [ADC_W-1:0] rawV;
        wire takeT = smpTick && smpPtr == 4'(r) && isTemp;
        wire [ADC_W-1:0] avg = sum[SW-1:AVG_SHIFT];
        wire [31:0] prod = 32'(cfg[r][W_TCAL][15:0]) * 32'(avg) * 32'(VREF_NUM);
        assign tempC[r] = cfg[r][W_TCAL][31:16] + prod[VREF_SHIFT +: VAL_W];

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                hPtr <= 4'h0;
                sum <= '0;
                for (int i = 0; i < AVG_DEPTH; i++) hist[i] <= '0;
            end else if (takeT) begin
                hist[hPtr] <= rawV;
                hPtr <= hPtr + 4'h1;
                sum <= sum + SW'(rawV) - SW'(hist[hPtr]);
            end
        end

        // Step through ADC results
        always_ff @(posedge ref_clk) begin
            if (srst) begin
                rawV <= '0;
                mv[r] <= '0;
            end else if (adcValid && adcChan == 4'(r)) begin
                rawV <= adcData;
                mv[r] <= isTemp ? tempC[r] : VAL_W'(adcData);
            end
        end

        // Window compares
        logic pg;
        logic everPg;
        logic [7:0] gCnt;
        wire live = (st[r] == RS_RAMP) || (st[r] == RS_ON);
        wire ovF = mv[r] > cfg[r][W_OVF][VAL_W-1:0];
        wire ovW = mv[r] > cfg[r][W_OVW][VAL_W-1:0];
        wire uvW = everPg && mv[r] < cfg[r][W_UVW][VAL_W-1:0];
        wire uvF = everPg && mv[r] < cfg[r][W_UVF][VAL_W-1:0];
        wire offLow = mv[r] <= (cfg[r][W_NOM][VAL_W-1:0] >> NOM_SHIFT);
        wire bad = ovF || uvF;
        wire gStep = (kind == TYPE_VOLT) ? glTick : smpTick;
        wire fltFault = bad && (!ctrl[F_FEN] || gCnt >= filt);

        always_ff @(posedge ref_clk) begin
            if (srst) pg <= 1'b0;
            else if (mv[r] >= cfg[r][W_PGON][VAL_W-1:0]) pg <= 1'b1;
            else if (mv[r] < cfg[r][W_PGOFF][VAL_W-1:0]) pg <= 1'b0;
        end
        always_ff @(posedge ref_clk) begin
            if (srst) everPg <= 1'b0;
            else if (live && pg) everPg <= 1'b1;
            else if (!live && st[r] != RS_OFFWAIT) everPg <= 1'b0;
        end
        always_ff @(posedge ref_clk) begin
            if (srst || !bad) gCnt <= 8'h00;
            else if (gStep && gCnt != 8'hFF) gCnt <= gCnt + 8'h01;
        end

        // Sequencer state
        logic [TMR_W-1:0] tmr;
        logic toRetry;
        logic toLock;
        logic reseq;
        rfm_rail_t nSt;
        logic [3:0] nRetry;
        logic nToRetry;
        logic nToLock;
        logic nReseq;
        logic tonEv;
        logic toffEv;
        logic faultEv;
        logic doShut;
        logic doReseq;
        wire canRetry = (rst == RST_CONT) || (rst == RST_COUNT && retries[r] < retryN
            && retries[r] < 4'(MAX_RETRY));

        always_comb begin
            nSt = st[r];
            nRetry = retries[r];
            nToRetry = toRetry;
            nToLock = toLock;
            nReseq = reseq;
            tonEv = 1'b0;
            toffEv = 1'b0;
            faultEv = 1'b0;
            doShut = 1'b0;
            doReseq = 1'b0;
            unique case (st[r])
                RS_IDLE: begin
                    nRetry = 4'h0;
                    if (enReq) nSt = RS_ONWAIT;
                end
                RS_ONWAIT: begin
                    if (!enReq && !reseq) nSt = RS_IDLE;
                    else if (tmr >= onWait) begin
                        nSt = RS_RAMP;
                        nReseq = 1'b0;
                    end
                end
                RS_RAMP: begin
                    faultEv = fltFault;
                    if (pg) nSt = RS_ON;
                    else if (tonMax != '0 && tmr >= tonMax) begin
                        tonEv = 1'b1;
                        faultEv = 1'b1;
                    end
                end
                RS_ON: faultEv = fltFault;
                RS_OFFWAIT: if (tmr >= offWait) nSt = RS_FALL;
                RS_FALL: begin
                    toffEv = toffMax != '0 && tmr >= toffMax && !offLow;
                    if (toRetry || reseq) nSt = RS_RETRY;
                    else if (offLow) nSt = toLock ? RS_LOCK : RS_IDLE;
                end
                RS_RETRY: begin
                    if (!enReq && !reseq) nSt = RS_IDLE;
                    else if (tmr >= restartT) nSt = reseq ? RS_ONWAIT : RS_RAMP;
                end
                RS_LOCK: if (!enReq) nSt = RS_IDLE;
            endcase
            if (live && !enReq && !reseq) begin
                nSt = RS_OFFWAIT;
                nToRetry = 1'b0;
                nToLock = 1'b0;
            end else if (live && faultEv && !reseq && resp != RESP_CONT) begin
                nToRetry = 1'b0;
                nToLock = 1'b1;
                if (canRetry) begin
                    nSt = RS_RETRY;
                    nToLock = 1'b0;
                    if (rst == RST_COUNT) nRetry = retries[r] + 4'h1;
                end else if (resp == RESP_DELAY) begin
                    nSt = RS_OFFWAIT;
                    doShut = 1'b1;
                end else if (resp == RESP_RESEQ) begin
                    nSt = RS_FALL;
                    nReseq = 1'b1;
                    nToLock = 1'b0;
                    doReseq = 1'b1;
                end else begin
                    nSt = RS_FALL;
                end
            end
            if (shutIn[r] && live && !reseq) begin
                nSt = RS_OFFWAIT;
                nToLock = 1'b1;
                nToRetry = 1'b0;
            end
            if (reseqIn[r] && !reseq && st[r] != RS_IDLE && st[r] != RS_LOCK) begin
                nSt = RS_FALL;
                nReseq = 1'b1;
                nToRetry = 1'b0;
                nToLock = 1'b0;
            end
        end

        always_ff @(posedge ref_clk) begin
            if (srst) begin
                st[r] <= RS_IDLE;
                retries[r] <= 4'h0;
                toRetry <= 1'b0;
                toLock <= 1'b0;
                reseq <= 1'b0;
                railEnable[r] <= 1'b0;
            end else begin
                st[r] <= nSt;
                retries[r] <= nRetry;
                toRetry <= nToRetry;
                toLock <= nToLock;
                reseq <= nReseq;
                railEnable[r] <= (nSt == RS_RAMP) || (nSt == RS_ON) || (nSt == RS_OFFWAIT);
            end
        end

        always_ff @(posedge ref_clk) begin
            if (srst || nSt != st[r]) tmr <= '0;
            else if (msTick && tmr != '1) tmr <= tmr + 1'b1;
        end

        // Sticky status, set wins over clear
        wire [5:0] clr = (wr && railIdx == 4'(r) && wordIdx == 4'(W_STAT)) ? pwdata[5:0] : 6'h00;
        wire [5:0] sets = {toffEv, tonEv, fltFault && uvF, uvW, ovW, fltFault && ovF};
        always_ff @(posedge ref_clk) begin
            if (srst) status[r] <= 6'h00;
            else status[r] <= (status[r] & ~clr) | sets;
        end
        assign statAny[r] = |status[r];
        assign shutOut[r] = doShut;
        assign reseqOut[r] = doReseq;
    end
endmodule
`default_nettype wire

// file: rfm_monitor_properties.sv
// Port-level checks of the rail fault response monitor
`timescale 1ns/10ps
`default_nettype none
module rfm_monitor_properties
    import rfm_pkg::*;
#(
    parameter int NUM_RAILS = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // ADC stream and pins
    input wire logic adcValid,
    input wire logic [3:0] adcChan,
    input wire logic [ADC_W-1:0] adcData,
    input wire logic bus_control_pin,
    input wire logic [NUM_RAILS-1:0] railEnable,
    input wire logic alert_out_n
);
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    wire setupPhase = psel && !penable;
    wire writeDone = psel && penable && pready && pwrite;
    wire badRail = 32'(paddr[9:6]) >= NUM_RAILS;
    a_ready_after_setup: assert property (setupPhase |=> pready)
        else $error("pready missing after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held two cycles");
    a_ready_cause: assert property ($rose(pready) |-> $past(setupPhase))
        else $error("pready without setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_bad_page: assert property (setupPhase && paddr[11:10] != 2'h0 |=>
        pslverr && prdata == 32'h0)
        else $error("unmapped page not refused");
    a_err_bad_rail: assert property (setupPhase && badRail |=> pslverr)
        else $error("absent rail not refused");
    a_rdata_stable: assert property (!$past(setupPhase) |-> $stable(prdata))
        else $error("read data moved outside setup");
    a_alert_sticky: assert property ($rose(alert_out_n) |-> $past(writeDone) || $past(writeDone, 2))
        else $error("alert released without clear");
endmodule
bind rfm_monitor rfm_monitor_properties #(.NUM_RAILS(NUM_RAILS)) i_props (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adcValid(adcValid), .adcChan(adcChan), .adcData(adcData),
    .bus_control_pin(bus_control_pin), .railEnable(railEnable), .alert_out_n(alert_out_n));
`default_nettype wire

// file: rfm_rail_model.sv
// Rail supplies and converter feeding the monitor
`timescale 1ns/10ps
`default_nettype none
module rfm_rail_model
    import rfm_pkg::*;
#(
    parameter int NUM_RAILS = 4,
    parameter logic [ADC_W-1:0] RAIL_LEVEL = 12'h400
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Rail enables
    input wire logic [NUM_RAILS-1:0] railEnable,
    // Result stream
    output logic adcValid,
    output logic [3:0] adcChan,
    output logic [ADC_W-1:0] adcData
);
    // Strobe every other cycle, round robin over rails
    wire [3:0] next_chan = 4'((32'(adcChan) + 1) % NUM_RAILS);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            adcValid <= 1'b0;
            adcChan <= 4'h0;
            adcData <= 12'h000;
        end else if (!adcValid) begin
            adcValid <= 1'b1;
            adcChan <= next_chan;
            adcData <= railEnable[next_chan] ? RAIL_LEVEL : 12'h000;
        end else begin
            // Inverted data between strobes
            adcValid <= 1'b0;
            adcData <= ~adcData;
        end
    end
endmodule
`default_nettype wire

// file: tb_top.sv
// Testbench of the rail fault response monitor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import rfm_pkg::*;
    localparam int NR = 4;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic ctlPin = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic adcValid;
    logic [3:0] adcChan;
    logic [ADC_W-1:0] adcData;
    logic [NR-1:0] railEnable;
    logic alert_out_n;
    logic [31:0] rd;
    int waited;
    int fail_count = 0;
    int n_tests = 0;

    always #5 ref_clk = ~ref_clk;

    rfm_monitor #(.NUM_RAILS(NR), .MS_CYCLES(10), .GLITCH_CYCLES(4), .SAMPLE_CYCLES(20)) i_dut (
        .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adcValid(adcValid), .adcChan(adcChan), .adcData(adcData),
        .bus_control_pin(ctlPin), .railEnable(railEnable), .alert_out_n(alert_out_n));
    rfm_rail_model #(.NUM_RAILS(NR)) i_rails (.ref_clk(ref_clk), .srst(srst),
        .railEnable(railEnable), .adcValid(adcValid), .adcChan(adcChan), .adcData(adcData));

    task automatic test_done();
        $display("Checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic guard(input int n, input int lim);
        if (n >= lim) begin
            chk("wait bound", 32'h0, 32'h1);
            test_done();
        end
    endtask

    // One APB transfer, ends one idle cycle after the access
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        guard(n, 50);
        rd = pslverr ? 32'hEEEEEEEE : prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic poll(input string what, input logic [11:0] a, input logic [31:0] m,
        input logic [31:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while ((rd & m) !== v && n < 300);
        if ((rd & m) !== v) guard(n, 300);
        chk(what, v, rd & m);
    endtask

    task automatic wait_en(input int r, input logic v);
        waited = 0;
        while (railEnable[r] !== v && waited < 3000) begin
            @(posedge ref_clk);
            waited++;
        end
        guard(waited, 3000);
    endtask

    function automatic logic [11:0] ra(input int r, input int w);
        return 12'(r * 64 + w * 4);
    endfunction

    function automatic logic [31:0] ctrl(input logic [1:0] rp, input logic [1:0] rs, input int n);
        return 32'h1 | (32'(rp) << F_RESP) | (32'(rs) << F_RST) | (32'(n) << F_RETRY);
    endfunction

    initial begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        poll("ovf reset", ra(0, W_OVF), '1, RST_OV);
        poll("ctrl reset", ra(1, W_CTRL), '1, RST_ZERO);
        apb(1'b0, 12'hC00, 32'h0);
        chk("bad page", 32'hEEEEEEEE, rd);
        apb(1'b1, ra(0, W_NUM), '1);
        chk("bad word", 32'hEEEEEEEE, rd);
        apb(1'b0, ra(NR, W_OVF), 32'h0);
        chk("bad rail", 32'hEEEEEEEE, rd);
        apb(1'b1, ra(0, W_TCAL), 32'h00190100);
        poll("temp", ra(0, W_READ), 32'hFFFF0000, 32'h00190000);
        $display("Test registers done");
        ctlPin <= 1'b1;
        apb(1'b1, ra(0, W_OVF), 32'h1);
        apb(1'b1, ra(0, W_OVW), 32'h1);
        apb(1'b1, ra(0, W_CTRL), ctrl(RESP_IMM, RST_NONE, 0));
        wait_en(0, 1'b1);
        wait_en(0, 1'b0);
        @(posedge ref_clk);
        chk("alert low", 32'h0, {31'h0, alert_out_n});
        repeat (200) @(posedge ref_clk);
        chk("rail0 stays off", 32'h0, {31'h0, railEnable[0]});
        chk("alert held", 32'h0, {31'h0, alert_out_n});
        poll("rail0 status", ra(0, W_STAT), 32'h7003, 32'h7003);
        apb(1'b1, ra(0, W_STAT), 32'h3F);
        @(posedge ref_clk);
        chk("alert cleared", 32'h1, {31'h0, alert_out_n});
        $display("Test immediate done");
        apb(1'b1, ra(1, W_OVF), 32'h1);
        apb(1'b1, ra(1, W_CTRL), ctrl(RESP_CONT, RST_NONE, 0));
        poll("rail1 status", ra(1, W_STAT), 32'h7001, 32'h3001);
        chk("rail1 on", 32'h1, {31'h0, railEnable[1]});
        $display("Test continue done");
        apb(1'b1, ra(1, W_TCAL), 32'h00190008);
        apb(1'b1, ra(1, W_CTRL), ctrl(RESP_CONT, RST_NONE, 0) | (32'(TYPE_TEMP) << F_TYPE));
        repeat (900) @(posedge ref_clk);
        apb(1'b0, ra(1, W_READ), 32'h0);
        chk("temp part", 32'h1, {31'h0, rd[31:16] > 16'h19 && rd[31:16] < 16'h1E});
        poll("temp average", ra(1, W_READ), 32'hFFFF0000, 32'h001E0000);
        apb(1'b1, ra(1, W_CTRL), ctrl(RESP_CONT, RST_NONE, 0));
        $display("Test temperature done");
        apb(1'b1, ra(2, W_OVF), 32'h1);
        apb(1'b1, ra(2, W_RSTRT), 32'h1);
        apb(1'b1, ra(2, W_CTRL), ctrl(RESP_IMM, RST_COUNT, 2));
        wait_en(2, 1'b1);
        wait_en(2, 1'b0);
        wait_en(2, 1'b1);
        chk("restart gap", 32'h1, {31'h0, waited >= 40 && waited <= 62});
        poll("rail2 lock", ra(2, W_STAT), 32'h7F01, 32'h7201);
        $display("Test counted done");
        apb(1'b1, ra(3, W_OVF), 32'h1);
        apb(1'b1, ra(3, W_WAIT), 32'h00030000);
        apb(1'b1, ra(3, W_RSTRT), 32'h200);
        apb(1'b1, ra(3, W_CTRL), ctrl(RESP_DELAY, RST_NONE, 0));
        wait_en(3, 1'b1);
        wait_en(3, 1'b0);
        chk("turn-off wait", 32'h1, {31'h0, waited >= 20 && waited <= 50});
        wait_en(1, 1'b0);
        $display("Test delayed done");
        ctlPin <= 1'b0;
        wait_en(2, 1'b0);
        apb(1'b1, ra(2, W_CTRL), ctrl(RESP_RESEQ, RST_CONT, 0));
        ctlPin <= 1'b1;
        wait_en(2, 1'b1);
        wait_en(2, 1'b0);
        wait_en(2, 1'b1);
        ctlPin <= 1'b0;
        wait_en(2, 1'b0);
        repeat (300) @(posedge ref_clk);
        chk("commanded off", 32'h0, {31'h0, railEnable[2]});
        $display("Test continuous done");
        apb(1'b1, ra(2, W_WAIT), 32'h00000002);
        apb(1'b1, ra(2, W_CTRL), ctrl(RESP_RESEQ, RST_COUNT, 1));
        ctlPin <= 1'b1;
        wait_en(2, 1'b1);
        wait_en(2, 1'b0);
        wait_en(2, 1'b1);
        chk("retry gap", 32'h1, {31'h0, waited <= 55});
        wait_en(2, 1'b0);
        wait_en(2, 1'b1);
        chk("reseq gap", 32'h1, {31'h0, waited >= 60 && waited <= 80});
        poll("rail2 retries", ra(2, W_STAT), 32'h0F00, 32'h0100);
        ctlPin <= 1'b0;
        wait_en(2, 1'b0);
        repeat (300) @(posedge ref_clk);
        chk("reseq off", 32'h0, {31'h0, railEnable[2]});
        $display("Test resequence done");
        test_done();
    end
endmodule
`default_nettype wire
